// [hdl/qdb4_port.sv]
// Command decode, DDR burst-of-four data path and storage of the RAM port
//
// Contract
// - Address and both selects are taken only on primary clock rising edges.
// - Both selects high at a primary edge is a deselect; nothing starts.
// - Read select low at a primary edge starts a four-beat read.
// - Read select is ignored right after a loaded read.
// - Write starts when write select low and read select high.
// - Write select is ignored right after a loaded write.
// - Write beats land on primary, complement, primary, complement edges after the command.
// - Read beats leave at primary and complement edges of n+2 and n+3.
// - Read select high begins a read-port deselect; no read data is scheduled.
// - Lane masks are sampled with their own data beat.
// - A masked lane keeps the stored nine bits unchanged.
// - Each write address takes four beats as one 144-bit array word.
// - Masks may change on every beat and act beat by beat.
// - Mask k gates data bits 9k to 9k+8, active low.
// - Termination is on only while the termination select pin is high.
// - A free-running counter triggers evaluations; each moves drive one step, except down from 0 or up from its maximum.
// - Drive uses binary-weighted steps; termination is readjusted the same way.
// - Beats three and four of the previous command always complete.
`timescale 1ns/1ps
`default_nettype none
module qdb4_port
  import qdb4_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     primary_clk_in,
  input  wire logic                     complement_clk_in,
  input  wire logic [qdb4_pkg::ADDR_W-1:0] sync_address_in,
  input  wire logic                     read_sel_n,
  input  wire logic                     write_sel_n,
  input  wire logic                     lane0_write_mask_n,
  input  wire logic                     lane1_write_mask_n,
  input  wire logic                     lane2_write_mask_n,
  input  wire logic                     lane3_write_mask_n,
  input  wire logic [qdb4_pkg::DATA_W-1:0] write_data,
  input  wire logic                     termination_select,
  input  wire logic                     impedance_reference_pin,
  output var  logic [qdb4_pkg::DATA_W-1:0] read_data,
  output var  logic                     read_data_oe,
  output var  logic                     termination_enable,
  output var  logic [qdb4_pkg::CODE_W-1:0] drive_code,
  output var  logic [qdb4_pkg::CODE_W-1:0] term_code
);
  import qdb4_pkg::*;

  // All pins cross together so their relative timing is kept
  logic [PIN_W-1:0]   pins_raw;
  logic [PIN_W-1:0]   pins_s;
  logic               prim_s;
  logic               comp_s;
  logic [ADDR_W-1:0]  addr_s;
  logic               rd_n_s;
  logic               wr_n_s;
  logic [LANES-1:0]   mask_n_s;
  logic [DATA_W-1:0]  wdata_s;
  logic               odt_s;
  logic               zq_cmp_s;

  assign pins_raw = {impedance_reference_pin,
                     termination_select,
                     write_data,
                     lane3_write_mask_n,
                     lane2_write_mask_n,
                     lane1_write_mask_n,
                     lane0_write_mask_n,
                     write_sel_n,
                     read_sel_n,
                     sync_address_in,
                     complement_clk_in,
                     primary_clk_in};

  qdb4_sync #(.W(PIN_W)) u_pin_sync (
    .clock (clock),
    .nrst  (nrst),
    .d_in  (pins_raw),
    .d_out (pins_s)
  );

  assign {zq_cmp_s, odt_s, wdata_s,
          mask_n_s, wr_n_s, rd_n_s,
          addr_s, comp_s, prim_s} = pins_s;

  // Edge detection of the two input clocks
  logic prim_prev_r;
  logic comp_prev_r;
  logic prim_rise;
  logic comp_rise;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prim_prev_r <= 1'b0;
      comp_prev_r <= 1'b0;
    end else begin
      prim_prev_r <= prim_s;
      comp_prev_r <= comp_s;
    end
  end

  // Edges count only once the synchroniser holds real pin values; an idle-high
  // clock pin would otherwise show a false rise just after reset
  logic [4:0] fill_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fill_r <= '0;
    end else begin
      fill_r <= {fill_r[3:0], 1'b1};
    end
  end

  assign prim_rise = prim_s & ~prim_prev_r & fill_r[4];
  assign comp_rise = comp_s & ~comp_prev_r & fill_r[4];

  // Command decode
  logic rd_s1_r;
  logic rd_s2_r;
  logic rd_s3_r;
  logic rd_s4_r;
  logic wr_s1_r;
  logic wr_s2_r;
  logic wr_s3_r;
  logic rd_take;
  logic wr_take;

  // Reads win whenever acceptable; right after a loaded read, read select is a
  // don't-care, so a write then needs only write select low
  assign rd_take = prim_rise && !rd_n_s && !rd_s1_r;
  assign wr_take = prim_rise && !wr_n_s && (rd_n_s || rd_s1_r) && !wr_s1_r;

  // Address latches, loaded only with an accepted command
  logic [ARRAY_AW-1:0] rd_addr_s1_r;
  logic [ARRAY_AW-1:0] rd_addr_r;
  logic [ARRAY_AW-1:0] wr_addr_s1_r;
  logic [ARRAY_AW-1:0] wr_addr_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_addr_s1_r <= '0;
      rd_addr_r    <= '0;
      wr_addr_s1_r <= '0;
      wr_addr_r    <= '0;
    end else if (prim_rise) begin
      if (rd_take) begin
        rd_addr_s1_r <= addr_s[ARRAY_AW-1:0];
      end
      if (wr_take) begin
        wr_addr_s1_r <= addr_s[ARRAY_AW-1:0];
      end
      if (rd_s1_r) begin
        rd_addr_r <= rd_addr_s1_r;
      end
      if (wr_s1_r) begin
        wr_addr_r <= wr_addr_s1_r;
      end
    end
  end

  // Stage bits advance on primary edges; later stages finish regardless of new commands
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_s3_r <= 1'b0;
      rd_s4_r <= 1'b0;
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
    end else if (prim_rise) begin
      rd_s1_r <= rd_take;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
      rd_s4_r <= rd_s3_r;
      wr_s1_r <= wr_take;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
    end
  end

  // Write beat capture: data and masks share the same edge
  logic [DATA_W-1:0] wbuf_r [BEATS-1];
  logic [LANES-1:0]  wmask_r [BEATS-1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < BEATS - 1; b++) begin
        wbuf_r[b]  <= '0;
        wmask_r[b] <= '1;
      end
    end else begin
      if (prim_rise && wr_s1_r) begin
        wbuf_r[0]  <= wdata_s;
        wmask_r[0] <= mask_n_s;
      end
      if (prim_rise && wr_s2_r) begin
        wbuf_r[2]  <= wdata_s;
        wmask_r[2] <= mask_n_s;
      end
      if (comp_rise && wr_s2_r) begin
        wbuf_r[1]  <= wdata_s;
        wmask_r[1] <= mask_n_s;
      end
    end
  end

  // Array: one 144-bit word per address, four beats side by side
  logic [WORD_W-1:0]     mem_r [2**ARRAY_AW];
  logic [WORD_W-1:0]     old_word;
  logic [WORD_W-1:0]     new_data;
  logic [BEAT_LANES-1:0] new_mask_n;
  logic [WORD_W-1:0]     merged;
  logic                  commit;

  // The fourth beat goes straight from the pins into the merge
  assign commit     = comp_rise && wr_s3_r;
  assign old_word   = mem_r[wr_addr_r];
  assign new_data   = {wdata_s, wbuf_r[2], wbuf_r[1], wbuf_r[0]};
  assign new_mask_n = {mask_n_s, wmask_r[2], wmask_r[1], wmask_r[0]};

  // Per beat and lane: a high mask keeps the stored nine bits
  for (genvar g = 0; g < BEAT_LANES; g++) begin : g_lane
    assign merged[g*LANE_W +: LANE_W] = new_mask_n[g] ? old_word[g*LANE_W +: LANE_W]
                                                      : new_data[g*LANE_W +: LANE_W];
  end

  // Storage holds no control state, so it carries no reset
  always_ff @(posedge clock) begin
    if (commit) begin
      mem_r[wr_addr_r] <= merged;
    end
  end

  // Read return: word latched at the first beat, beats in order low to high
  logic [WORD_W-1:0] rd_word_r;
  logic [WORD_W-1:0] rd_fetch;

  assign rd_fetch = mem_r[rd_addr_r];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_word_r <= '0;
    end else if (prim_rise && rd_s2_r) begin
      rd_word_r <= rd_fetch;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data    <= '0;
      read_data_oe <= 1'b0;
    end else if (prim_rise) begin
      if (rd_s2_r) begin
        read_data    <= rd_fetch[0 +: DATA_W];
        read_data_oe <= 1'b1;
      end else if (rd_s3_r) begin
        read_data    <= rd_word_r[2*DATA_W +: DATA_W];
        read_data_oe <= 1'b1;
      end else begin
        read_data_oe <= 1'b0;
      end
    end else if (comp_rise) begin
      if (rd_s3_r) begin
        read_data    <= rd_word_r[DATA_W +: DATA_W];
        read_data_oe <= 1'b1;
      end else if (rd_s4_r) begin
        read_data    <= rd_word_r[3*DATA_W +: DATA_W];
        read_data_oe <= 1'b1;
      end else begin
        read_data_oe <= 1'b0;
      end
    end
  end

  // Termination follows the select pin; a floating pin reads low outside
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      termination_enable <= 1'b0;
    end else begin
      termination_enable <= odt_s;
    end
  end

  // Impedance calibration engine
  qdb4_cal_if cal_bus ();

  assign cal_bus.cmp_high = zq_cmp_s;

  qdb4_imp_cal u_cal (
    .clock (clock),
    .nrst  (nrst),
    .cal   (cal_bus.cal)
  );

  assign drive_code = cal_bus.drive_code;
  assign term_code  = cal_bus.term_code;
endmodule : qdb4_port
`default_nettype wire

// [hdl/qdb4_pkg.sv]
// Constants and types shared by the burst-of-four DDR static RAM port
`default_nettype none
package qdb4_pkg;
  localparam int ADDR_W        = 20;
  localparam int ARRAY_AW      = 4;
  localparam int LANES         = 4;
  localparam int LANE_W        = 9;
  localparam int DATA_W        = 36;
  localparam int BEATS         = 4;
  localparam int WORD_W        = 144;
  localparam int BEAT_LANES    = 16;
  localparam int CODE_W        = 5;
  localparam logic [4:0] CODE_RST = 5'h10;
  localparam logic [4:0] CODE_MAX = 5'h1f;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CAL_PERIOD_NS = 4096;
  localparam int CAL_CYCLES    = CAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CAL_CNT_W     = 10;
  localparam logic [9:0] CAL_LAST = 10'(CAL_CYCLES - 1);
  localparam int PIN_W         = 66;

  typedef enum logic [0:0] {
    QDB4_CAL_COUNT = 1'b0,
    QDB4_CAL_EVAL  = 1'b1
  } qdb4_cal_state_t;
endpackage : qdb4_pkg
`default_nettype wire

// [hdl/qdb4_cal_if.sv]
// Signals between the port core and the impedance calibration engine
`timescale 1ns/1ps
`default_nettype none
interface qdb4_cal_if;
  import qdb4_pkg::*;
  logic              cmp_high;
  logic [CODE_W-1:0] drive_code;
  logic [CODE_W-1:0] term_code;
  logic              eval_pulse;
  modport cal  (input cmp_high, output drive_code, output term_code, output eval_pulse);
  modport core (output cmp_high, input drive_code, input term_code, input eval_pulse);
endinterface : qdb4_cal_if
`default_nettype wire

// [hdl/qdb4_sync.sv]
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module qdb4_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] d_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Stage one feeds stage two only; the filter looks at two and three
  logic [W-1:0] out_nxt;

  for (genvar g = 0; g < W; g++) begin : g_bit
    assign out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : d_out[g];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      d_out <= '0;
    end else begin
      d_out <= out_nxt;
    end
  end
endmodule : qdb4_sync
`default_nettype wire

// [hdl/qdb4_imp_cal.sv]
// Periodic output driver and termination impedance calibration
`timescale 1ns/1ps
`default_nettype none
module qdb4_imp_cal
  import qdb4_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  qdb4_cal_if.cal   cal
);
  qdb4_cal_state_t       state_r;
  logic [CAL_CNT_W-1:0]  cnt_r;
  logic [CODE_W-1:0]     drive_r;
  logic [CODE_W-1:0]     term_r;
  logic                  eval_r;

  // Free-running counter restarts after every evaluation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= QDB4_CAL_COUNT;
      cnt_r   <= '0;
      eval_r  <= 1'b0;
    end else begin
      eval_r <= 1'b0;
      case (state_r)
        QDB4_CAL_COUNT: begin
          if (cnt_r == CAL_LAST) begin
            cnt_r   <= '0;
            state_r <= QDB4_CAL_EVAL;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        QDB4_CAL_EVAL: begin
          eval_r  <= 1'b1;
          state_r <= QDB4_CAL_COUNT;
        end
        default: state_r <= QDB4_CAL_COUNT;
      endcase
    end
  end

  // One binary-weighted step per evaluation; a high compare adds drive legs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drive_r <= CODE_RST;
      term_r  <= CODE_RST;
    end else if (state_r == QDB4_CAL_EVAL) begin
      if (cal.cmp_high && drive_r != CODE_MAX) begin
        drive_r <= drive_r + 1'b1;
      end else if (!cal.cmp_high && drive_r != '0) begin
        drive_r <= drive_r - 1'b1;
      end
      if (cal.cmp_high && term_r != CODE_MAX) begin
        term_r <= term_r + 1'b1;
      end else if (!cal.cmp_high && term_r != '0) begin
        term_r <= term_r - 1'b1;
      end
    end
  end

  assign cal.drive_code = drive_r;
  assign cal.term_code  = term_r;
  assign cal.eval_pulse = eval_r;
endmodule : qdb4_imp_cal
`default_nettype wire

// [verification/qdb4_host_model.sv]
// Host controller model: input clocks, commands and write beats for the RAM port
`timescale 1ns/1ps
`default_nettype none
module qdb4_host_model
  import qdb4_pkg::*;
#(
  parameter int HALF = 8
) (
  input  wire logic                        clock,
  input  wire logic [qdb4_pkg::DATA_W-1:0] read_data,
  input  wire logic                        read_data_oe,
  output var  logic                        primary_clk_in,
  output var  logic                        complement_clk_in,
  output var  logic [qdb4_pkg::ADDR_W-1:0] sync_address_in,
  output var  logic                        read_sel_n,
  output var  logic                        write_sel_n,
  output var  logic [qdb4_pkg::LANES-1:0]  mask_n,
  output var  logic [qdb4_pkg::DATA_W-1:0] write_data
);
  // Output seen just before the next pin edge, enable in the top bit
  logic [DATA_W:0] q_kb;
  logic [DATA_W:0] q_k;
  initial begin
    primary_clk_in    = 1'b0;
    complement_clk_in = 1'b1;
    sync_address_in   = '0;
    read_sel_n        = 1'b1;
    write_sel_n       = 1'b1;
    mask_n            = '1;
    write_data        = '0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk
  // Data pins move midway between edges and commands on the complement edge, so no pin changes near the edge that samples it
  task automatic kcycle(input logic r_n, input logic w_n, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d0, input logic [LANES-1:0] m0,
                        input logic [DATA_W-1:0] d1, input logic [LANES-1:0] m1);
    primary_clk_in    = 1'b0;
    complement_clk_in = 1'b1;
    read_sel_n        = r_n;
    write_sel_n       = w_n;
    sync_address_in   = a;
    wait_clk(HALF / 2);
    write_data        = d0;
    mask_n            = m0;
    wait_clk(HALF / 2 - 1);
    q_kb              = {read_data_oe, read_data};
    wait_clk(1);
    primary_clk_in    = 1'b1;
    complement_clk_in = 1'b0;
    wait_clk(HALF / 2);
    write_data        = d1;
    mask_n            = m1;
    wait_clk(HALF / 2 - 1);
    q_k               = {read_data_oe, read_data};
    wait_clk(1);
  endtask : kcycle
endmodule : qdb4_host_model
`default_nettype wire

// [verification/qdb4_port_chk.sv]
// Concurrent checks on the RAM port top
`timescale 1ns/1ps
`default_nettype none
module qdb4_port_chk
  import qdb4_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        nrst,
  input wire logic                        read_sel_n,
  input wire logic                        impedance_reference_pin,
  input wire logic                        termination_select,
  input wire logic                        read_data_oe,
  input wire logic                        termination_enable,
  input wire logic [qdb4_pkg::CODE_W-1:0] drive_code,
  input wire logic [qdb4_pkg::CODE_W-1:0] term_code
);
  // Return bound sized for an eight-clock half period of the input clocks
  localparam logic [6:0] RD_GAP = 7'h28;
  logic [10:0] gap_r;
  logic [6:0]  since_rd_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gap_r <= '0;
    end else if ($changed(drive_code) || $changed(term_code)) begin
      gap_r <= '0;
    end else if (gap_r != 11'h7ff) begin
      gap_r <= gap_r + 11'h001;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst || !read_sel_n) begin
      since_rd_r <= '0;
    end else if (since_rd_r != 7'h7f) begin
      since_rd_r <= since_rd_r + 7'h01;
    end
  end
  property p_rst;
    $rose(nrst) |-> !read_data_oe && drive_code == CODE_RST && term_code == CODE_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs off reset values");
  property p_dstep;
    $changed(drive_code) |-> drive_code == $past(drive_code) + 5'h01 || drive_code == $past(drive_code) - 5'h01;
  endproperty
  a_dstep: assert property (p_dstep) else $error("drive code jumped");
  property p_tstep;
    $changed(term_code) |-> term_code == $past(term_code) + 5'h01 || term_code == $past(term_code) - 5'h01;
  endproperty
  a_tstep: assert property (p_tstep) else $error("term code jumped");
  // Slack of a few clocks covers the first evaluation after reset
  property p_gap;
    $changed(drive_code) || $changed(term_code) |-> gap_r >= 11'h3fc;
  endproperty
  a_gap: assert property (p_gap) else $error("evaluations too close");
  property p_dir;
    $changed(drive_code) |-> (drive_code > $past(drive_code)) == $past(impedance_reference_pin, 8);
  endproperty
  a_dir: assert property (p_dir) else $error("drive code moved the wrong way");
  property p_term;
    $stable(termination_select) [*8] |-> termination_enable == termination_select;
  endproperty
  a_term: assert property (p_term) else $error("termination enable wrong");
  property p_oe_len;
    $rose(read_data_oe) |-> read_data_oe [*8];
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("read burst cut short");
  property p_oe_src;
    $rose(read_data_oe) |-> since_rd_r <= RD_GAP;
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("read data without read");
endmodule : qdb4_port_chk
bind qdb4_port qdb4_port_chk i_chk (.clock, .nrst, .read_sel_n, .impedance_reference_pin, .termination_select,
  .read_data_oe, .termination_enable, .drive_code, .term_code);
`default_nettype wire

// [verification/qdb4_port_tb_top.sv]
// Self-checking bench for the burst-of-four DDR RAM port
`timescale 1ns/1ps
`default_nettype none
module qdb4_port_tb_top;
  import qdb4_pkg::*;
  logic              clock, nrst, termination_select, impedance_reference_pin;
  logic              primary_clk_in, complement_clk_in, read_sel_n, write_sel_n, read_data_oe, termination_enable;
  logic [ADDR_W-1:0] sync_address_in, c_a [16];
  logic [LANES-1:0]  mask_n, c_m [32];
  logic [DATA_W-1:0] write_data, read_data, c_d [32];
  logic [CODE_W-1:0] drive_code, term_code;
  logic [DATA_W:0]   lg_k [16], lg_kb [16];
  logic              c_rn [16], c_wn [16];
  int                mismatches = 0, num_checks = 0, cycles = 0;
  qdb4_port i_dut (
    .clock, .nrst, .primary_clk_in, .complement_clk_in, .sync_address_in, .read_sel_n, .write_sel_n,
    .lane0_write_mask_n(mask_n[0]), .lane1_write_mask_n(mask_n[1]), .lane2_write_mask_n(mask_n[2]),
    .lane3_write_mask_n(mask_n[3]), .write_data, .termination_select, .impedance_reference_pin,
    .read_data, .read_data_oe, .termination_enable, .drive_code, .term_code);
  qdb4_host_model #(.HALF(8)) i_host (.clock, .read_data, .read_data_oe, .primary_clk_in, .complement_clk_in,
    .sync_address_in, .read_sel_n, .write_sel_n, .mask_n, .write_data);
  function automatic logic [WORD_W-1:0] pat(input logic [7:0] x);
    logic [WORD_W-1:0] w;
    for (int b = 0; b < BEATS; b++) w[DATA_W*b +: DATA_W] = {x, x, x, x, 4'(b)};
    return w;
  endfunction : pat
  task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic plan_wr(input int n, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w,
                         input logic [BEAT_LANES-1:0] m);
    c_wn[n] = 1'b0;
    c_a[n]  = a;
    for (int b = 0; b < BEATS; b++) begin
      c_d[2*n+2+b] = w[DATA_W*b +: DATA_W];
      c_m[2*n+2+b] = m[LANES*b +: LANES];
    end
  endtask : plan_wr
  task automatic plan_rd(input int n, input logic [ADDR_W-1:0] a);
    c_rn[n] = 1'b0;
    c_a[n]  = a;
  endtask : plan_rd
  // Plays the planned primary periods, then leaves an idle plan behind
  task automatic run(input int len);
    for (int i = 0; i < len; i++) begin
      i_host.kcycle(c_rn[i], c_wn[i], c_a[i], c_d[2*i], c_m[2*i], c_d[2*i+1], c_m[2*i+1]);
      lg_kb[i] = i_host.q_kb;
      lg_k[i]  = i_host.q_k;
    end
    for (int i = 0; i < 32; i++) begin
      c_d[i]    = '0;
      c_m[i]    = '1;
      c_rn[i/2] = 1'b1;
      c_wn[i/2] = 1'b1;
      c_a[i/2]  = '0;
    end
  endtask : run
  task automatic chk_rd(input int n, input logic [WORD_W-1:0] w);
    check("beat0", lg_k[n+2], {1'b1, w[0 +: DATA_W]});
    check("beat1", lg_kb[n+3], {1'b1, w[DATA_W +: DATA_W]});
    check("beat2", lg_k[n+3], {1'b1, w[2*DATA_W +: DATA_W]});
    check("beat3", lg_kb[n+4], {1'b1, w[3*DATA_W +: DATA_W]});
  endtask : chk_rd
  task automatic chk_idle(input int n);
    check("idle", lg_k[n][DATA_W], 1'b0);
  endtask : chk_idle
  task automatic t_rw();
    plan_wr(0, 20'h00001, pat(8'ha1), '0);
    plan_rd(1, 20'h00001);
    plan_wr(2, 20'h00004, pat(8'hb2), '0);
    plan_rd(3, 20'h00004);
    plan_rd(5, 20'h00001);
    run(10);
    chk_rd(1, pat(8'ha1));
    chk_rd(3, pat(8'hb2));
    chk_rd(5, pat(8'ha1));
    chk_idle(2);
    chk_idle(9);
  endtask : t_rw
  task automatic t_mask();
    logic [WORD_W-1:0] exp;
    for (int l = 0; l < BEAT_LANES; l++) begin
      exp[LANE_W*l +: LANE_W] = (16'h0f96 >> l) & 1 ? pat(8'ha1) >> (LANE_W*l) : pat(8'hc3) >> (LANE_W*l);
    end
    plan_wr(0, 20'h00001, pat(8'hc3), 16'h0f96);
    plan_rd(2, 20'h00001);
    run(8);
    chk_rd(2, exp);
  endtask : t_mask
  task automatic t_refuse();
    plan_wr(0, 20'h00003, pat(8'hd4), '0);
    c_wn[1] = 1'b0;
    c_a[1]  = 20'h00004;
    plan_rd(2, 20'h00004);
    // Read select low right after a read is ignored, so this write still lands
    plan_wr(3, 20'h00003, pat(8'hf6), '0);
    plan_rd(3, 20'h00003);
    plan_wr(7, 20'h00003, pat(8'he5), '0);
    plan_rd(7, 20'h00003);
    plan_rd(9, 20'h00003);
    run(14);
    chk_rd(2, pat(8'hb2));
    chk_idle(6);
    chk_rd(7, pat(8'hf6));
    chk_rd(9, pat(8'hf6));
    chk_idle(13);
  endtask : t_refuse
  task automatic t_term();
    termination_select = 1'b1;
    step(10);
    check("term on", termination_enable, 1'b1);
    termination_select = 1'b0;
    step(10);
    check("term off", termination_enable, 1'b0);
  endtask : t_term
  task automatic wait_code();
    logic [CODE_W-1:0] old;
    old = drive_code;
    for (int i = 0; i < 1100 && drive_code === old; i++) step(1);
  endtask : wait_code
  // The comparator only moves right after an evaluation, so no evaluation sees it half settled
  task automatic t_cal();
    logic [CODE_W-1:0] d, t;
    wait_code();
    impedance_reference_pin = 1'b1;
    d = drive_code;
    t = term_code;
    wait_code();
    check("drive up", drive_code, 5'(d + 5'h01));
    check("term up", term_code, 5'(t + 5'h01));
    impedance_reference_pin = 1'b0;
    wait_code();
    check("drive down", drive_code, d);
    check("term down", term_code, t);
  endtask : t_cal
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    nrst                    = 1'b0;
    termination_select      = 1'b0;
    impedance_reference_pin = 1'b0;
    run(0);
    step(5);
    nrst = 1'b1;
    step(8);
    t_rw();
    t_mask();
    t_refuse();
    t_term();
    t_cal();
    results();
  end
endmodule : qdb4_port_tb_top
`default_nettype wire
